/* File: cmd_parser_pkg.sv */
/*
 Shared constants, types and character helpers of the command line parser.
 Assumes one 40 MHz clock and byte-wide streams.
*/
package cmd_parser_pkg;
   localparam logic [15:0] CMD_TCP_PORT = 16'hD6D8; // 55000
   localparam int unsigned LINE_MAX = 40;
   localparam int unsigned VAL_MAX = 38;
   localparam int unsigned RD_MAX = 16;
   localparam int unsigned TXQ_DEPTH = 4;
   localparam int unsigned TXQ_WIDTH = 8;
   localparam longint unsigned CLK_HZ = 40_000_000;
   localparam longint unsigned IDLE_TIMEOUT_S = 30;
   localparam int unsigned IDLE_TIMEOUT_CYC = 32'(CLK_HZ * IDLE_TIMEOUT_S);
   localparam logic [1:0] MAX_WEB = 2'h2;
   localparam logic [1:0] MAX_RAW = 2'h1;
   localparam logic [1:0] MAX_OPCUA = 2'h2;
   localparam logic [1:0] MAX_PPMP = 2'h1;
   localparam int unsigned GROSS_STATUS_BIT = 3;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_DQ = 8'h22;
   localparam logic [7:0] CH_SQ = 8'h27;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_QM = 8'h3F;
   localparam logic [7:0] CH_X = 8'h78;

   typedef enum logic [1:0] {SESS_WEB, SESS_RAW, SESS_OPCUA, SESS_PPMP} sess_kind_t;

   typedef struct packed {
      logic                      write;
      logic [15:0]               index;
      logic [7:0]                subindex;
      logic [5:0]                val_len;
      logic [VAL_MAX-1:0][7:0]   val_text;
   } od_req_t;

   typedef struct packed {
      logic                      ok;
      logic                      nan;
      logic [4:0]                len;
      logic [RD_MAX-1:0][7:0]    text;
   } od_rsp_t;

   typedef struct packed {
      logic [7:0]                data;
      logic                      last;
   } rec_byte_t;

   function automatic logic is_dec(input logic [7:0] c);
      return c >= 8'h30 && c <= 8'h39;
   endfunction

   function automatic logic is_hex(input logic [7:0] c);
      return is_dec(c) || (c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66);
   endfunction

   function automatic logic [3:0] nibble(input logic [7:0] c);
      if (is_dec(c)) return 4'(c - 8'h30);
      return 4'(c[3:0] + 4'h9);
   endfunction
endpackage

/* File: byte_queue.sv */
/*
 Small synchronous queue with valid/ready on both sides.
 Assumes one clock; flush empties it at once.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_queue #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
   logic [AW-1:0]               wr_reg;
   logic [AW-1:0]               rd_reg;
   logic [AW:0]                 cnt_reg;
   logic                        push;
   logic                        pop;

   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) mem_reg[wr_reg] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_reg + 1'b1);
         if (pop) rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_reg + 1'b1);
         cnt_reg <= (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
      end
   end
endmodule // byte_queue
`default_nettype wire

/* File: line_assembler.sv */
/*
 Gathers received bytes into one command line, ended by LF or CR LF.
 Assumes the parser pulses take once it has answered the line.
*/
`timescale 1ns/1ps
`default_nettype none
module line_assembler
   import cmd_parser_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     flush,
   input  wire logic                     in_valid,
   input  wire logic [7:0]               in_data,
   output logic                          in_ready,
   input  wire logic                     take,
   output logic                          line_valid,
   output logic      [5:0]               line_len,
   output logic                          line_long,
   output logic      [LINE_MAX-1:0][7:0] line_chars
);
   logic [LINE_MAX-1:0][7:0] buf_reg;
   logic [5:0]               cnt_reg;
   logic                     cr_reg;
   logic                     done_reg;
   logic [5:0]               len_reg;
   logic                     long_reg;
   logic                     acc;

   assign in_ready = !done_reg;
   assign acc = in_valid && in_ready;
   assign line_valid = done_reg;
   assign line_len = len_reg;
   assign line_long = long_reg;
   assign line_chars = buf_reg;

   always_ff @(posedge clk) begin
      if (acc && in_data != CH_LF && cnt_reg < 6'(LINE_MAX)) buf_reg[cnt_reg] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         cnt_reg <= '0;
         cr_reg <= 1'b0;
         done_reg <= 1'b0;
         len_reg <= '0;
         long_reg <= 1'b0;
      end else if (acc && in_data == CH_LF) begin
         done_reg <= 1'b1;
         long_reg <= cnt_reg >= 6'(LINE_MAX);
         len_reg <= cr_reg ? 6'(cnt_reg - 1'b1) : cnt_reg;
         cnt_reg <= '0;
         cr_reg <= 1'b0;
      end else if (acc) begin
         if (cnt_reg <= 6'(LINE_MAX)) cnt_reg <= 6'(cnt_reg + 1'b1);
         cr_reg <= in_data == CH_CR;
      end else if (take) begin
         done_reg <= 1'b0;
      end
   end
endmodule // line_assembler
`default_nettype wire

/* File: ascii_object_command_parser.sv */
/*
 Line command interpreter of the control port: object write/read and recorder dump.
 Assumes a TCP stack outside that delivers session events and a byte stream,
 an object dictionary port that answers each request once, and a recorder byte source.
*/
`timescale 1ns/1ps
`default_nettype none
module ascii_object_command_parser
   import cmd_parser_pkg::*;
#(
   parameter int unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   output logic             tx_valid,
   output logic      [7:0]  tx_data,
   input  wire logic        tx_ready,
   input  wire logic        sess_open,
   input  wire sess_kind_t  sess_kind,
   input  wire logic [15:0] sess_port,
   output logic             sess_grant,
   input  wire logic        sess_close,
   input  wire sess_kind_t  sess_close_kind,
   output logic             cmd_conn_active,
   output logic             conn_drop,
   output logic             od_req_valid,
   output od_req_t          od_req,
   input  wire logic        od_rsp_valid,
   input  wire od_rsp_t     od_rsp,
   input  wire logic        rec_valid,
   input  wire rec_byte_t   rec,
   output logic             rec_ready,
   output logic             rec_clear,
   input  wire logic [31:0] meas_status,
   output logic             gross_valid
);
   typedef enum {
      ST_WAIT, ST_KEY, ST_FIELD, ST_VALUE, ST_OD_WAIT,
      ST_SEND_DATA, ST_SEND_CODE, ST_DUMP, ST_CR, ST_LF, ST_DONE
   } parse_state_t;

   parse_state_t             state_reg;
   logic [5:0]               pos_reg;
   logic                     fld_reg;
   logic [16:0]              acc_reg;
   logic [2:0]               digits_reg;
   logic                     hex_reg;
   logic                     write_reg;
   logic [15:0]              idx_reg;
   logic [5:0]               vstart_reg;
   logic                     seen_reg;
   logic                     quoted_reg;
   logic                     closed_reg;
   logic [7:0]               code_reg;
   logic                     dump_reg;
   od_req_t                  od_req_reg;
   logic                     od_valid_reg;
   od_rsp_t                  rsp_reg;
   logic [1:0]               web_reg;
   logic [1:0]               raw_reg;
   logic [1:0]               opc_reg;
   logic [1:0]               ppmp_reg;
   logic [31:0]              idle_reg;
   logic                     drop_reg;
   logic                     gross_reg;

   logic                     asm_ready;
   logic                     line_valid;
   logic [5:0]               line_len;
   logic                     line_long;
   logic [LINE_MAX-1:0][7:0] line_chars;
   logic                     line_take;
   logic                     flush;
   logic                     push_valid;
   logic [7:0]               push_data;
   logic                     push_ready;
   logic                     push_fire;
   logic [7:0]               c;
   logic                     at_end;
   logic [5:0]               val_len;
   logic                     raw_close;

   assign raw_close = sess_close && sess_close_kind == SESS_RAW;
   assign flush = drop_reg || raw_close;
   assign cmd_conn_active = raw_reg != 2'h0;
   assign rx_ready = asm_ready && cmd_conn_active;
   assign conn_drop = drop_reg;
   assign od_req = od_req_reg;
   assign od_req_valid = od_valid_reg;
   assign gross_valid = gross_reg;
   assign at_end = pos_reg >= line_len;
   assign c = (pos_reg < 6'(LINE_MAX)) ? line_chars[pos_reg] : 8'h00;
   assign val_len = 6'(line_len - vstart_reg);
   assign push_fire = push_valid && push_ready;
   assign line_take = state_reg == ST_DONE;
   assign rec_clear = state_reg == ST_DONE && dump_reg;

   line_assembler u_line (
      .clk        (clk),
      .rst        (rst),
      .flush      (flush),
      .in_valid   (rx_valid && cmd_conn_active),
      .in_data    (rx_data),
      .in_ready   (asm_ready),
      .take       (line_take),
      .line_valid (line_valid),
      .line_len   (line_len),
      .line_long  (line_long),
      .line_chars (line_chars)
   );

   byte_queue #(
      .WIDTH (TXQ_WIDTH),
      .DEPTH (TXQ_DEPTH)
   ) u_txq (
      .clk       (clk),
      .rst       (rst),
      .flush     (flush),
      .in_valid  (push_valid),
      .in_data   (push_data),
      .in_ready  (push_ready),
      .out_valid (tx_valid),
      .out_data  (tx_data),
      .out_ready (tx_ready)
   );

   // session admission; a stack refusal is a missing grant in the open cycle
   always_comb begin
      sess_grant = 1'b0;
      if (sess_open) begin
         case (sess_kind)
            SESS_WEB:   sess_grant = web_reg < MAX_WEB;
            SESS_RAW:   sess_grant = sess_port == CMD_TCP_PORT && raw_reg < MAX_RAW;
            SESS_OPCUA: sess_grant = opc_reg < MAX_OPCUA && ppmp_reg == 2'h0;
            SESS_PPMP:  sess_grant = ppmp_reg < MAX_PPMP && opc_reg == 2'h0;
            default:    sess_grant = 1'b0;
         endcase
      end
   end

   function automatic logic [1:0] sess_count(input logic [1:0] cnt, input logic inc, input logic dec);
      if (inc && !dec) return 2'(cnt + 1'b1);
      if (dec && !inc && cnt != 2'h0) return 2'(cnt - 1'b1);
      return cnt;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         web_reg <= 2'h0;
         raw_reg <= 2'h0;
         opc_reg <= 2'h0;
         ppmp_reg <= 2'h0;
      end else begin
         web_reg <= sess_count(web_reg, sess_grant && sess_kind == SESS_WEB,
                               sess_close && sess_close_kind == SESS_WEB);
         raw_reg <= sess_count(raw_reg, sess_grant && sess_kind == SESS_RAW, raw_close || drop_reg);
         opc_reg <= sess_count(opc_reg, sess_grant && sess_kind == SESS_OPCUA,
                               sess_close && sess_close_kind == SESS_OPCUA);
         ppmp_reg <= sess_count(ppmp_reg, sess_grant && sess_kind == SESS_PPMP,
                                sess_close && sess_close_kind == SESS_PPMP);
      end
   end

   // idle time restarts on any byte taken in or sent out
   always_ff @(posedge clk) begin
      if (rst || !cmd_conn_active || drop_reg || (rx_valid && rx_ready) || (tx_valid && tx_ready)) begin
         idle_reg <= '0;
         drop_reg <= 1'b0;
      end else if (idle_reg >= IDLE_TIMEOUT_CYCLES - 1) begin
         drop_reg <= 1'b1;
      end else begin
         idle_reg <= idle_reg + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) gross_reg <= 1'b0;
      else gross_reg <= !meas_status[GROSS_STATUS_BIT];
   end

   always_comb begin
      push_valid = 1'b0;
      push_data = 8'h00;
      rec_ready = 1'b0;
      case (state_reg)
         ST_SEND_CODE: begin
            push_valid = 1'b1;
            push_data = code_reg;
         end
         ST_SEND_DATA: begin
            push_valid = 1'b1;
            push_data = rsp_reg.text[pos_reg[3:0]];
         end
         ST_DUMP: begin
            push_valid = rec_valid;
            push_data = rec.data;
            rec_ready = push_ready;
         end
         ST_CR: begin
            push_valid = 1'b1;
            push_data = CH_CR;
         end
         ST_LF: begin
            push_valid = 1'b1;
            push_data = CH_LF;
         end
         default: push_valid = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst || flush) begin
         state_reg <= ST_WAIT;
         pos_reg <= '0;
         fld_reg <= 1'b0;
         acc_reg <= '0;
         digits_reg <= '0;
         hex_reg <= 1'b0;
         write_reg <= 1'b0;
         idx_reg <= '0;
         vstart_reg <= '0;
         seen_reg <= 1'b0;
         quoted_reg <= 1'b0;
         closed_reg <= 1'b0;
         code_reg <= CH_QM;
         dump_reg <= 1'b0;
         od_req_reg <= '0;
         od_valid_reg <= 1'b0;
         rsp_reg <= '0;
      end else begin
         case (state_reg)
            ST_WAIT: begin
               if (line_valid) state_reg <= ST_KEY;
            end
            ST_KEY: begin
               pos_reg <= 6'h4;
               fld_reg <= 1'b0;
               acc_reg <= '0;
               digits_reg <= '0;
               hex_reg <= 1'b0;
               seen_reg <= 1'b0;
               quoted_reg <= 1'b0;
               closed_reg <= 1'b0;
               code_reg <= CH_QM;
               state_reg <= ST_SEND_CODE;
               if (!line_long && line_len >= 6'h4) begin
                  if (line_chars[0] == 8'h53 && line_chars[1] == 8'h44 && line_chars[2] == 8'h4F) begin
                     if (line_chars[3] == CH_QM || line_chars[3] == CH_SP) begin
                        write_reg <= line_chars[3] == CH_SP;
                        state_reg <= ST_FIELD;
                     end
                  end else if (line_len == 6'h4 && line_chars[0] == 8'h52 && line_chars[1] == 8'h4D
                               && line_chars[2] == 8'h42 && line_chars[3] == CH_QM) begin
                     dump_reg <= 1'b1;
                     state_reg <= ST_DUMP;
                  end
               end
            end
            ST_FIELD: begin
               pos_reg <= 6'(pos_reg + 1'b1);
               if (at_end || c == CH_COMMA) begin
                  acc_reg <= '0;
                  digits_reg <= '0;
                  hex_reg <= 1'b0;
                  if (digits_reg == 3'h0 || acc_reg[16] || (fld_reg && acc_reg > 17'h000FF)) begin
                     state_reg <= ST_SEND_CODE;
                  end else if (!fld_reg) begin
                     idx_reg <= acc_reg[15:0];
                     fld_reg <= 1'b1;
                     if (at_end) state_reg <= ST_SEND_CODE;
                  end else if (!write_reg && at_end) begin
                     od_req_reg.write <= 1'b0;
                     od_req_reg.index <= idx_reg;
                     od_req_reg.subindex <= acc_reg[7:0];
                     od_req_reg.val_len <= '0;
                     od_req_reg.val_text <= '0;
                     od_valid_reg <= 1'b1;
                     state_reg <= ST_OD_WAIT;
                  end else if (write_reg && !at_end) begin
                     od_req_reg.subindex <= acc_reg[7:0];
                     vstart_reg <= 6'(pos_reg + 1'b1);
                     state_reg <= ST_VALUE;
                  end else begin
                     state_reg <= ST_SEND_CODE;
                  end
               end else if (c == CH_SP && digits_reg == 3'h0 && !hex_reg) begin
                  digits_reg <= digits_reg;
               end else if ((c == CH_X || c == 8'h58) && digits_reg == 3'h1 && acc_reg == '0 && !hex_reg) begin
                  hex_reg <= 1'b1;
                  digits_reg <= '0;
               end else if (hex_reg && is_hex(c) && digits_reg < 3'h4) begin
                  acc_reg <= {acc_reg[12:0], nibble(c)};
                  digits_reg <= 3'(digits_reg + 1'b1);
               end else if (!hex_reg && is_dec(c) && digits_reg < 3'h5) begin
                  acc_reg <= 17'(acc_reg * 17'h0000A) + 17'(nibble(c));
                  digits_reg <= 3'(digits_reg + 1'b1);
               end else begin
                  state_reg <= ST_SEND_CODE;
               end
            end
            ST_VALUE: begin
               pos_reg <= 6'(pos_reg + 1'b1);
               if (at_end) begin
                  // the value must be present even where the object ignores it
                  if (!seen_reg || (quoted_reg && !closed_reg)) begin
                     state_reg <= ST_SEND_CODE;
                  end else begin
                     od_req_reg.write <= 1'b1;
                     od_req_reg.index <= idx_reg;
                     od_req_reg.val_len <= val_len;
                     for (int i = 0; i < VAL_MAX; i++) begin
                        od_req_reg.val_text[i] <= (i < int'(val_len)) ? line_chars[6'(vstart_reg + 6'(i))] : 8'h00;
                     end
                     od_valid_reg <= 1'b1;
                     state_reg <= ST_OD_WAIT;
                  end
               end else if (!seen_reg) begin
                  if (c == CH_SP) begin
                     vstart_reg <= 6'(pos_reg + 1'b1);
                  end else if (c == CH_SQ || c == CH_QM) begin
                     state_reg <= ST_SEND_CODE;
                  end else begin
                     seen_reg <= 1'b1;
                     quoted_reg <= c == CH_DQ;
                  end
               end else if (closed_reg || (!quoted_reg && c == CH_DQ) || c == CH_SQ || c == CH_QM) begin
                  state_reg <= ST_SEND_CODE;
               end else if (quoted_reg && c == CH_DQ) begin
                  closed_reg <= 1'b1;
               end
            end
            ST_OD_WAIT: begin
               if (od_rsp_valid) begin
                  od_valid_reg <= 1'b0;
                  rsp_reg <= od_rsp;
                  pos_reg <= '0;
                  code_reg <= (od_rsp.ok && od_req_reg.write) ? CH_ZERO : CH_QM;
                  if (!od_req_reg.write && od_rsp.ok && !od_rsp.nan && od_rsp.len != 5'h0) begin
                     state_reg <= ST_SEND_DATA;
                  end else begin
                     state_reg <= ST_SEND_CODE;
                  end
               end
            end
            ST_SEND_DATA: begin
               if (push_fire) begin
                  if (pos_reg == 6'(rsp_reg.len - 1'b1) || pos_reg == 6'(RD_MAX - 1)) state_reg <= ST_CR;
                  else pos_reg <= 6'(pos_reg + 1'b1);
               end
            end
            ST_SEND_CODE: begin
               if (push_fire) state_reg <= ST_CR;
            end
            ST_DUMP: begin
               if (push_fire && rec.last) state_reg <= ST_CR;
            end
            ST_CR: begin
               if (push_fire) state_reg <= ST_LF;
            end
            ST_LF: begin
               if (push_fire) state_reg <= ST_DONE;
            end
            ST_DONE: begin
               dump_reg <= 1'b0;
               state_reg <= ST_WAIT;
            end
            default: state_reg <= ST_WAIT;
         endcase
      end
   end
endmodule // ascii_object_command_parser
`default_nettype wire

/* File: cmd_parser_monitor.sv */
/* Port checks of the command parser.
   Bound onto the parser from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module cmd_parser_monitor
   import cmd_parser_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        tx_valid,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_ready,
   input wire logic        rx_ready,
   input wire logic        sess_open,
   input wire sess_kind_t  sess_kind,
   input wire logic [15:0] sess_port,
   input wire logic        sess_grant,
   input wire logic        sess_close,
   input wire logic        cmd_conn_active,
   input wire logic        conn_drop,
   input wire logic        od_req_valid,
   input wire od_req_t     od_req,
   input wire logic        od_rsp_valid,
   input wire logic [31:0] meas_status,
   input wire logic        gross_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire raw_open = sess_open && sess_kind == SESS_RAW;
   port_check_a:
      assert property (raw_open && sess_port != CMD_TCP_PORT |-> !sess_grant) else $error("raw grant on bad port");
   one_client_a:
      assert property (raw_open && cmd_conn_active |-> !sess_grant) else $error("second raw grant");
   grant_open_a:
      assert property (raw_open && sess_grant |=> cmd_conn_active) else $error("raw grant not active");
   rx_gate_a:
      assert property (conn_drop |=> !rx_ready && !tx_valid) else $error("port open after drop");
   drop_close_a:
      assert property (conn_drop |=> !conn_drop ##1 !cmd_conn_active) else $error("drop did not close");
   od_hold_a:
      assert property (disable iff (rst || conn_drop) od_req_valid && !od_rsp_valid |=> od_req_valid && $stable(od_req))
         else $error("request not held");
   tx_hold_a:
      assert property (disable iff (rst || conn_drop || sess_close) tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
         else $error("reply byte not held");
   gross_flag_a:
      assert property (!$past(rst) |-> gross_valid == !$past(meas_status[3])) else $error("gross flag wrong");
endmodule // cmd_parser_monitor
`default_nettype wire

/* File: od_dict_model.sv */
/* Object dictionary on the far side: answers each request once after lat cycles.
   Reply text is fixed; ok and nan come from the bench. */
`timescale 1ns/1ps
`default_nettype none
module od_dict_model
   import cmd_parser_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       od_req_valid,
   input  wire od_req_t    od_req,
   input  wire logic       ok,
   input  wire logic       nan,
   input  wire logic [3:0] lat,
   output logic            od_rsp_valid,
   output od_rsp_t         od_rsp
);
   localparam string VAL = "1500.496";
   logic [3:0] wait_q;
   logic       done_q;
   always @(posedge clk) begin
      od_rsp_valid <= 1'b0;
      if (rst || !od_req_valid) begin
         wait_q <= 4'h0;
         done_q <= 1'b0;
      end else if (!done_q && wait_q >= lat) begin
         od_rsp_valid <= 1'b1;
         done_q <= 1'b1;
      end else
         wait_q <= wait_q + 4'h1;
   end
   // outside the answer cycle the bus shows the inverse, never a stale copy
   always_comb begin
      od_rsp = '0;
      od_rsp.ok = ok;
      od_rsp.nan = nan;
      od_rsp.len = 5'h08;
      for (int i = 0; i < 8; i++)
         od_rsp.text[i] = VAL[i];
      if (!od_rsp_valid)
         od_rsp = ~od_rsp;
   end
endmodule // od_dict_model
`default_nettype wire

/* File: ascii_object_command_parser_tb_top.sv */
/* Self-checking bench: sessions, command lines, dump and idle drop.
   Expected reply bytes are queued from the rules and popped per taken byte. */
`timescale 1ns/1ps
`default_nettype none
module ascii_object_command_parser_tb_top
   import cmd_parser_pkg::*;
();
   logic clk = 1'b0, rst = 1'b1, rx_valid = 1'b0, tx_ready = 1'b0, sess_open = 1'b0, sess_close = 1'b0;
   logic rec_valid = 1'b0, ok = 1'b1, nan = 1'b0, clr_seen = 1'b0, ms3_q, rst_q;
   logic rx_ready, tx_valid, sess_grant, cmd_conn_active, conn_drop, od_req_valid, od_rsp_valid;
   logic rec_ready, rec_clear, gross_valid;
   logic [7:0] rx_data = 8'h00, tx_data, exp_q[$];
   logic [15:0] sess_port = 16'h0000;
   logic [31:0] meas_status = 32'h0, seed = 32'h3E;
   logic [3:0] lat = 4'h0;
   sess_kind_t sess_kind = SESS_WEB, sess_close_kind = SESS_WEB;
   od_req_t od_req;
   od_rsp_t od_rsp;
   rec_byte_t rec = '0;
   int n_errors = 0, tests_run = 0;
   ascii_object_command_parser #(.IDLE_TIMEOUT_CYCLES(120)) u_ascii_object_command_parser (.*);
   od_dict_model u_od_dict_model (.*);
   initial forever #12.5 clk = ~clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %0h seen %0h", what, e, g);
         n_errors++;
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic sess(sess_kind_t k, logic [15:0] p, logic g);
      sess_open <= 1'b1;
      sess_kind <= k;
      sess_port <= p;
      @(posedge clk);
      chk("sess_grant", {31'h0, g}, {31'h0, sess_grant});
      sess_open <= 1'b0;
      @(posedge clk);
   endtask
   // drives the line in and waits eight more cycles with tx_ready low, then drives tx_ready at random for each byte of the reply
   task automatic send(string s, string r);
      lat <= 4'(xs()) & 4'h7;
      for (int i = 0; i < s.len(); i++) begin
         rx_valid <= 1'b1;
         rx_data <= s[i];
         do @(posedge clk); while (!rx_ready);
      end
      rx_valid <= 1'b0;
      for (int i = 0; i < r.len(); i++) exp_q.push_back(r[i]);
      repeat (8) @(posedge clk);
      for (int i = 0; i < r.len(); i++) begin
         do begin tx_ready <= 1'(xs()); @(posedge clk); end while (!(tx_valid && tx_ready));
         chk("tx_data", {24'h0, exp_q.pop_front()}, {24'h0, tx_data});
      end
      tx_ready <= 1'b0;
      $display("line test done, %0d checks", tests_run);
   endtask
   always @(posedge clk) begin
      if (!rst && !rst_q) chk("gross_valid", {31'h0, ~ms3_q}, {31'h0, gross_valid});
      if (rec_clear === 1'b1) clr_seen <= 1'b1;
      ms3_q <= meas_status[3];
      rst_q <= rst;
      meas_status <= xs();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sess(SESS_RAW, 16'h1234, 1'b0);
      sess(SESS_RAW, CMD_TCP_PORT, 1'b1);
      sess(SESS_RAW, CMD_TCP_PORT, 1'b0);
      for (int i = 0; i < 3; i++) sess(SESS_WEB, 16'h0050, i < 2);
      for (int i = 0; i < 3; i++) sess(SESS_OPCUA, 16'h1234, i < 2);
      sess(SESS_PPMP, 16'h1234, 1'b0);
      send("SDO? 0x44f0,4\n", "1500.496\r\n");
      chk("od_req", 32'h0044F004, {7'h0, od_req.write, od_req.index, od_req.subindex});
      send("SDO 0x4410,4,0\r\n", "0\r\n");
      chk("od_req", 32'h01441004, {7'h0, od_req.write, od_req.index, od_req.subindex});
      nan <= 1'b1;
      send("SDO? 0x44f0,4\r\n", "?\r\n");
      ok <= 1'b0;
      nan <= 1'b0;
      send("SDO 0x4400,1,0\n", "?\r\n");
      send("XYZ\n", "?\r\n");
      send({"SDO 1,1,", {36{"0"}}, "\n"}, "?\r\n");
      ok <= 1'b1;
      send("SDO? 1,1\n", "1500.496\r\n");
      send("SDO 1,1,\"AB\"\n", "0\r\n");
      fork
         for (int i = 0; i < 4; i++) begin
            rec_valid <= 1'b1;
            rec <= {8'(32'h48445237 >> (24 - 8 * i)), i == 3};
            do @(posedge clk); while (!rec_ready);
         end
      join_none
      send({string'(32'h524D423F), "\n"}, "HDR7\r\n");
      rec_valid <= 1'b0;
      repeat (4) @(posedge clk);
      chk("rec_clear", 32'h1, {31'h0, clr_seen});
      for (int i = 0; i < 200 && conn_drop !== 1'b1; i++) @(posedge clk);
      chk("conn_drop", 32'h1, {31'h0, conn_drop});
      repeat (2) @(posedge clk);
      chk("cmd_conn_active", 32'h0, {31'h0, cmd_conn_active});
      report_and_stop();
   end
   initial begin
      #500_000;
      n_errors++;
      report_and_stop();
   end
endmodule // ascii_object_command_parser_tb_top
bind ascii_object_command_parser cmd_parser_monitor u_cmd_parser_monitor (.*);
`default_nettype wire
